// ---- src/indirect_addr_pkg.sv ----
// package of constants and types for the indirect addressing unit
package indirect_addr_pkg;
	// ------------------------------------------------------------
	// register offsets (word index, byte address is four times it)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_PORT_ZERO = 8'h00;
	localparam logic [7:0] OFS_POINTER_ZERO = 8'h01;
	localparam logic [7:0] OFS_PORT_ONE = 8'h08;
	localparam logic [7:0] OFS_POINTER_ONE = 8'h09;
	localparam logic [7:0] OFS_ALU_STATUS = 8'h04;
	localparam logic [7:0] OFS_BANK_SELECT = 8'h0f;
	localparam logic [7:0] OFS_BANKED_LO = 8'h10;
	localparam logic [7:0] OFS_BANKED_HI = 8'h17;
	localparam logic [7:0] OFS_GPR_LO = 8'h20;
	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int POS_MODE_ZERO = 0;
	localparam int POS_MODE_ONE = 2;
	localparam int POS_ZERO_FLAG = 4;
	localparam logic [7:0] RST_ALU_STATUS = 8'h00;
	localparam logic [7:0] RST_BANK_SELECT = 8'h00;
	localparam logic [7:0] RST_POINTER = 8'h00;
	// number of implemented banks in each banked region
	localparam logic [3:0] NUM_SFR_BANKS = 4'h4;
	localparam logic [3:0] NUM_GPR_BANKS = 4'h4;
	// ------------------------------------------------------------
	// post access update codes
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_DEC = 2'b00,
		MODE_INC = 2'b01,
		MODE_HOLD = 2'b10,
		MODE_HOLD2 = 2'b11
	} update_mode_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_READ = 2'b01,
		ST_ACK = 2'b10
	} bus_state_t;
endpackage

// ---- src/data_ram.sv ----
// data memory of the indirect addressing unit, registered read
`timescale 1ns/1ps
module data_ram (
	input wire logic i_clk,
	input wire logic i_we,
	input wire logic [11:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);
	logic [7:0] mem [0:4095];
	// ------------------------------------------------------------
	// write and registered read
	// ------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end
endmodule

// ---- src/indirect_data_addressing.sv ----
// indirect data addressing unit with wishbone register access
// Summary of operation
// - two channels, each port plus pointer
// - port accesses the location its pointer addresses
// - pointers are eight bits, full range
// - banked targets use bank select register
// - indirect read of a port gives zero
// - indirect write of a port is no-op
// - two bits choose decrement, increment or hold
// - status bits 3:2 pointer one, 1:0 zero
// - pointer updates never touch status flags
// - pointer zero: read zero, write no-op
// - port transfer completes in one access
// - low nibble sfr bank, high gpr bank
// - unimplemented bank reads zero, drops writes
`timescale 1ns/1ps
module indirect_data_addressing
	import indirect_addr_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [9:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack
);
	bus_state_t state_reg;
	logic [7:0] address_pointer_zero_reg;
	logic [7:0] address_pointer_one_reg;
	logic [7:0] alu_status_register_reg;
	logic [7:0] bank_select_register_reg;
	logic [31:0] rdata_reg;
	logic [7:0] word_index;
	logic access;
	logic is_port_zero;
	logic is_port_one;
	logic is_port;
	logic [7:0] target;
	logic ram_hit;
	logic ram_valid;
	logic [11:0] ram_addr;
	logic ram_we;
	logic [7:0] ram_rdata;
	logic use_ram_reg;
	logic zero_read_reg;
	logic [7:0] direct_rdata;

	// ------------------------------------------------------------
	// helper functions
	// ------------------------------------------------------------
	// next pointer value after an indirect access
	function automatic logic [7:0] next_pointer(input logic [7:0] ptr, input logic [1:0] mode);
		logic [7:0] r;
		r = ptr;
		case (mode)
			MODE_DEC: r = ptr - 8'h01;
			MODE_INC: r = ptr + 8'h01;
			default: r = ptr;
		endcase
		return r;
	endfunction

	// true when the address names one of the virtual ports
	function automatic logic names_port(input logic [7:0] a);
		return (a == OFS_PORT_ZERO) || (a == OFS_PORT_ONE);
	endfunction

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	assign word_index = i_wb_adr[9:2];
	assign access = i_wb_cyc && i_wb_stb && (state_reg == ST_IDLE);
	assign is_port_zero = (word_index == OFS_PORT_ZERO);
	assign is_port_one = (word_index == OFS_PORT_ONE);
	assign is_port = is_port_zero || is_port_one;

	// target is the pointer of the port, else the direct address
	always_comb begin
		if (is_port_zero) begin
			target = address_pointer_zero_reg;
		end else if (is_port_one) begin
			target = address_pointer_one_reg;
		end else begin
			target = word_index;
		end
	end

	// map target to physical ram address through the bank selection
	always_comb begin
		ram_hit = 1'b0;
		ram_valid = 1'b0;
		ram_addr = 12'h000;
		if (target >= OFS_BANKED_LO && target <= OFS_BANKED_HI) begin
			ram_hit = 1'b1;
			ram_valid = (bank_select_register_reg[3:0] < NUM_SFR_BANKS);
			ram_addr = {1'b1, bank_select_register_reg[3:0], 4'h0, target[2:0]}; // kept apart from gpr banks
		end else if (target >= OFS_GPR_LO) begin
			ram_hit = 1'b1;
			ram_valid = (bank_select_register_reg[7:4] < NUM_GPR_BANKS);
			ram_addr = {bank_select_register_reg[7:4], target};
		end else if (target != OFS_ALU_STATUS && target != OFS_BANK_SELECT && !names_port(target)
			&& target != OFS_POINTER_ZERO && target != OFS_POINTER_ONE) begin
			ram_hit = 1'b1;
			ram_valid = 1'b1;
			ram_addr = {4'hf, target};
		end
	end

	// writes reach ram only through a valid bank and never a port target
	assign ram_we = access && i_wb_we && i_wb_sel[0] && ram_hit && ram_valid
		&& !(is_port && (names_port(target) || target == OFS_POINTER_ZERO));

	data_ram u_ram (
		.i_clk(i_clk),
		.i_we(ram_we),
		.i_addr(ram_addr),
		.i_wdata(i_wb_dat[7:0]),
		.o_rdata(ram_rdata)
	);

	// direct register read value
	always_comb begin
		if (target == OFS_POINTER_ZERO && !is_port) begin
			direct_rdata = address_pointer_zero_reg;
		end else if (target == OFS_POINTER_ONE && !is_port) begin
			direct_rdata = address_pointer_one_reg;
		end else if (target == OFS_ALU_STATUS) begin
			direct_rdata = alu_status_register_reg;
		end else if (target == OFS_BANK_SELECT) begin
			direct_rdata = bank_select_register_reg;
		end else begin
			direct_rdata = 8'h00;
		end
	end

	// ------------------------------------------------------------
	// bus state machine
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (access) begin
						state_reg <= i_wb_we ? ST_ACK : ST_READ;
					end
				end
				ST_READ: state_reg <= ST_ACK;
				ST_ACK: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	assign o_wb_ack = (state_reg == ST_ACK);

	// read path selection captured at the request
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			use_ram_reg <= 1'b0;
			zero_read_reg <= 1'b0;
		end else if (access && !i_wb_we) begin
			use_ram_reg <= ram_hit && ram_valid;
			zero_read_reg <= is_port && (names_port(target) || target == OFS_POINTER_ZERO);
		end
	end

	// read data register
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			rdata_reg <= 32'h00000000;
		end else if (access && !i_wb_we) begin
			rdata_reg <= {24'h000000, direct_rdata};
		end else if (state_reg == ST_READ) begin
			if (zero_read_reg) begin
				rdata_reg <= 32'h00000000;
			end else if (use_ram_reg) begin
				rdata_reg <= {24'h000000, ram_rdata};
			end
			// register targets and missing banks keep the value taken at the request
		end
	end

	assign o_wb_dat = (state_reg == ST_ACK) ? rdata_reg : 32'h00000000;

	// ------------------------------------------------------------
	// pointers: direct write or post access update
	// ------------------------------------------------------------
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			address_pointer_zero_reg <= RST_POINTER;
			address_pointer_one_reg <= RST_POINTER;
		end else if (access) begin
			if (is_port_zero) begin
				address_pointer_zero_reg <= next_pointer(address_pointer_zero_reg,
					alu_status_register_reg[POS_MODE_ZERO+1:POS_MODE_ZERO]);
			end else if (is_port_one) begin
				address_pointer_one_reg <= next_pointer(address_pointer_one_reg,
					alu_status_register_reg[POS_MODE_ONE+1:POS_MODE_ONE]);
			end else if (i_wb_we && i_wb_sel[0] && word_index == OFS_POINTER_ZERO) begin
				address_pointer_zero_reg <= i_wb_dat[7:0];
			end else if (i_wb_we && i_wb_sel[0] && word_index == OFS_POINTER_ONE) begin
				address_pointer_one_reg <= i_wb_dat[7:0];
			end
		end
	end

	// ------------------------------------------------------------
	// status and bank select registers
	// ------------------------------------------------------------
	// zero flag set by a zero read through a port; pointer steps leave it
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			alu_status_register_reg <= RST_ALU_STATUS;
		end else if (access && !i_wb_we && is_port && (names_port(target) || target == OFS_POINTER_ZERO)) begin
			alu_status_register_reg[POS_ZERO_FLAG] <= 1'b1;
		end else if (access && i_wb_we && i_wb_sel[0] && !is_port && word_index == OFS_ALU_STATUS) begin
			alu_status_register_reg <= i_wb_dat[7:0];
		end
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			bank_select_register_reg <= RST_BANK_SELECT;
		end else if (access && i_wb_we && i_wb_sel[0] && !is_port && word_index == OFS_BANK_SELECT) begin
			bank_select_register_reg <= i_wb_dat[7:0];
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	property p_ack_latency;
		@(posedge i_clk) disable iff (i_rst)
		access |-> ##[1:2] o_wb_ack;
	endproperty
	a_ack_latency: assert property (p_ack_latency) else $error("ack late");

	property p_inc;
		@(posedge i_clk) disable iff (i_rst)
		(access && is_port_zero && alu_status_register_reg[1:0] == 2'b01)
			|=> address_pointer_zero_reg == $past(address_pointer_zero_reg) + 8'h01;
	endproperty
	a_inc: assert property (p_inc) else $error("pointer zero no increment");

	property p_dec;
		@(posedge i_clk) disable iff (i_rst)
		(access && is_port_one && alu_status_register_reg[3:2] == 2'b00)
			|=> address_pointer_one_reg == $past(address_pointer_one_reg) - 8'h01;
	endproperty
	a_dec: assert property (p_dec) else $error("pointer one no decrement");

	property p_hold;
		@(posedge i_clk) disable iff (i_rst)
		(access && is_port_zero && alu_status_register_reg[1])
			|=> $stable(address_pointer_zero_reg);
	endproperty
	a_hold: assert property (p_hold) else $error("pointer moved in hold");

	property p_zero_read;
		@(posedge i_clk) disable iff (i_rst)
		(access && !i_wb_we && is_port_zero && address_pointer_zero_reg == 8'h00)
			|-> ##2 (o_wb_ack && o_wb_dat == 32'h00000000);
	endproperty
	a_zero_read: assert property (p_zero_read) else $error("null read not zero");

	property p_port_write_nop;
		@(posedge i_clk) disable iff (i_rst)
		(access && i_wb_we && is_port && names_port(target)) |-> !ram_we;
	endproperty
	a_port_write_nop: assert property (p_port_write_nop) else $error("port write stored");

	property p_zflag;
		@(posedge i_clk) disable iff (i_rst)
		(access && !i_wb_we && is_port_one && names_port(address_pointer_one_reg))
			|=> alu_status_register_reg[POS_ZERO_FLAG];
	endproperty
	a_zflag: assert property (p_zflag) else $error("zero flag not set");

	property p_no_flag_on_step;
		@(posedge i_clk) disable iff (i_rst)
		(access && i_wb_we && is_port) |=> $stable(alu_status_register_reg);
	endproperty
	a_no_flag_on_step: assert property (p_no_flag_on_step) else $error("status changed by step");

	property p_bank_drop;
		@(posedge i_clk) disable iff (i_rst)
		(ram_hit && !ram_valid) |-> !ram_we;
	endproperty
	a_bank_drop: assert property (p_bank_drop) else $error("write to missing bank");
endmodule

// ---- verif/core_bus_model.sv ----
// wishbone master standing in for the processor core
`timescale 1ns/1ps
module core_bus_model (
	input wire logic i_clk,
	input wire logic [31:0] i_wb_dat,
	input wire logic i_wb_ack,
	output logic o_wb_cyc,
	output logic o_wb_stb,
	output logic o_wb_we,
	output logic [9:0] o_wb_adr,
	output logic [3:0] o_wb_sel,
	output logic [31:0] o_wb_dat
);
	// idle bus at time zero
	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we = 1'b0;
		o_wb_adr = 10'h000;
		o_wb_sel = 4'h1;
		o_wb_dat = 32'h0;
	end

	// one classic cycle, hands back read data and edges waited
	task automatic access(input logic we, input logic [7:0] idx, input logic [7:0] wd,
		output logic [31:0] rd, output int n);
		n = 0;
		@(posedge i_clk);
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= we;
		o_wb_adr <= {idx, 2'b00};
		o_wb_dat <= {24'h0, wd};
		do begin
			@(posedge i_clk);
			n++;
		end while (i_wb_ack !== 1'b1);
		rd = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_adr <= ~o_wb_adr; // released lines carry no stale value
		o_wb_dat <= ~o_wb_dat;
	endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench for the indirect addressing unit
`timescale 1ns/1ps
module tb_top;
	import indirect_addr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc;
	logic wb_stb;
	logic wb_we;
	logic [9:0] wb_adr;
	logic [3:0] wb_sel;
	logic [31:0] wb_wdat;
	logic [31:0] wb_rdat;
	logic wb_ack;
	int num_errors = 0;
	int num_checks = 0;
	int cycles = 0;

	// 200 MHz clock
	always #2.5 clk = ~clk;

	indirect_data_addressing i_indirect_data_addressing (
		.i_clk(clk), .i_rst(rst), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb), .i_wb_we(wb_we),
		.i_wb_adr(wb_adr), .i_wb_sel(wb_sel), .i_wb_dat(wb_wdat), .o_wb_dat(wb_rdat), .o_wb_ack(wb_ack)
	);

	core_bus_model i_core_bus_model (
		.i_clk(clk), .i_wb_dat(wb_rdat), .i_wb_ack(wb_ack), .o_wb_cyc(wb_cyc), .o_wb_stb(wb_stb),
		.o_wb_we(wb_we), .o_wb_adr(wb_adr), .o_wb_sel(wb_sel), .o_wb_dat(wb_wdat)
	);

	// ------------------------------------------------------------
	// reporting and bus helpers
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("errors %0d checks %0d", num_errors, num_checks);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [31:0] r;
		int n;
		i_core_bus_model.access(1'b1, idx, d, r, n);
		check(32'(n), 32'h2);
	endtask

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		logic [31:0] r;
		int n;
		i_core_bus_model.access(1'b0, idx, 8'h00, r, n);
		check(32'(n), 32'h3);
		check(r, {24'h0, exp});
	endtask

	// hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			stop_test();
		end
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		rd(8'h01, 8'h00);
		rd(8'h09, 8'h00);
		rd(8'h04, 8'h00);
		rd(8'h0f, 8'h00);
		// pointer zero steps up, pointer one steps down
		wr(8'h04, 8'h01);
		wr(8'h01, 8'h30);
		wr(8'h00, 8'ha5);
		wr(8'h00, 8'h5a);
		rd(8'h01, 8'h32);
		wr(8'h09, 8'h31);
		rd(8'h08, 8'h5a);
		rd(8'h08, 8'ha5);
		rd(8'h09, 8'h2f);
		rd(8'h04, 8'h01);
		// pointer one wraps, pointer zero set to hold
		wr(8'h04, 8'h06);
		wr(8'h09, 8'hff);
		wr(8'h08, 8'h77);
		rd(8'h09, 8'h00);
		rd(8'h04, 8'h06);
		rd(8'h08, 8'h00);
		rd(8'h04, 8'h16);
		wr(8'h09, 8'h00);
		wr(8'h08, 8'h99);
		rd(8'h04, 8'h16);
		// target is a port itself
		wr(8'h04, 8'h06);
		wr(8'h09, 8'h08);
		rd(8'h08, 8'h00);
		rd(8'h04, 8'h16);
		wr(8'h04, 8'h06);
		wr(8'h09, 8'h08);
		wr(8'h08, 8'h3c);
		rd(8'h04, 8'h06);
		// banked special registers, low nibble
		wr(8'h01, 8'h12);
		wr(8'h00, 8'h11);
		wr(8'h0f, 8'h03);
		wr(8'h00, 8'h22);
		wr(8'h0f, 8'h05);
		wr(8'h00, 8'h33);
		rd(8'h00, 8'h00);
		wr(8'h0f, 8'h00);
		rd(8'h00, 8'h11);
		wr(8'h0f, 8'h03);
		rd(8'h00, 8'h22);
		// banked ram, high nibble
		wr(8'h01, 8'h40);
		wr(8'h0f, 8'h00);
		wr(8'h00, 8'h44);
		wr(8'h0f, 8'h30);
		wr(8'h00, 8'h55);
		wr(8'h0f, 8'h70);
		wr(8'h00, 8'h66);
		rd(8'h00, 8'h00);
		wr(8'h0f, 8'h00);
		rd(8'h00, 8'h44);
		wr(8'h0f, 8'h30);
		rd(8'h00, 8'h55);
		stop_test();
	end
endmodule
